// ===== rtl/rec_top.sv
// Regulator enable control: power-down, strap and voltage-select logic for
// the analog, core and USB regulators, with a small register port.
// Assumes straps are static and synchronous to clk_i; rtc_por_n_i comes from
// the always-on RTC core supply and is released only when it powers up.
`timescale 1ns/1ns

// Functional notes
// R1: A one on either power-down bit switches off all three regulators together.
// R2: Once shut down, no register write re-enables regulators; only RTC supply cycling does.
// R3: Analog regulator is always on except under the shared power-down bits.
// R4: Core regulator enabled while its strap is low, disabled while high.
// R5: Core regulator strap selects how the internal reset is produced.
// R6: Voltage-select bit switches core output 1.3 V / 1.05 V; 1.3 V after reset.
// R7: A disabled core or USB regulator leaves its output pin high-impedance.
// R8: Clock strap high: USB regulator starts disabled, software enables or disables it.
// R9: Clock strap low: USB regulator on after reset; enable bit cannot turn it off.
// R10: Bandgap power-down also stops bandgap and analog POR; regulator power-down keeps bandgap.
// R11: Power-down request is stored in the RTC supply domain until it cycles.
module rec_top
  import rec_pkg::*;
(
  // Clock, enable and resets
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  rtc_por_n_i,
  input  wire logic                  ce_i,
  // Register port
  input  wire logic [REC_ADDR_W-1:0] addr_i,
  input  wire logic [REC_DATA_W-1:0] wdata_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic      [REC_DATA_W-1:0] rdata_o,
  // Board straps
  input  wire logic                  core_regulator_strap_i,
  input  wire logic                  clock_source_strap_i,
  // Regulator controls
  output logic                       analog_regulator_en_o,
  output logic                       core_regulator_out_o,
  output logic                       core_regulator_oe_o,
  output logic                       core_voltage_select_o,
  output logic                       usb_regulator_out_o,
  output logic                       usb_regulator_oe_o,
  output logic                       bandgap_en_o,
  output logic                       analog_por_en_o,
  // Reset generation
  output logic                       internal_por_select_o,
  output logic                       chip_reset_n_o
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  rec_rtc_pm_t             pm_state;
  rec_rtc_pm_t             pm_wdata;
  rec_supply_t             supply_next;
  rec_supply_t             supply_reg;
  logic                    pm_hit;
  logic                    rc_hit;
  logic                    pm_wr;
  logic                    rc_wr;
  logic                    shutdown;
  logic                    vsel_reg;
  logic                    usb_en_reg;
  logic                    clk_sel_reg;
  logic                    straps_taken_reg;
  logic                    chip_reset_n_reg;
  logic                    chip_reset_n_next;
  logic [REC_DATA_W-1:0]   rdata_reg;
  logic [REC_DATA_W-1:0]   rdata_next;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign pm_hit = (addr_i == REC_RTC_PM_OFS);
  assign rc_hit = (addr_i == REC_REG_CTRL_OFS);
  assign pm_wr  = wr_i && pm_hit;
  assign rc_wr  = wr_i && rc_hit;

  assign pm_wdata.clkout_en = wdata_i[REC_PM_CLKOUT_BIT];
  assign pm_wdata.regulator_shutdown_bit    = wdata_i[REC_PM_REGULATOR_SHUTDOWN_BIT_BIT];
  assign pm_wdata.bandgap_shutdown_bit     = wdata_i[REC_PM_BANDGAP_SHUTDOWN_BIT_BIT];
  assign pm_wdata.wake_dir  = wdata_i[REC_PM_WAKE_DIR_BIT];
  assign pm_wdata.wake_out  = wdata_i[REC_PM_WAKE_OUT_BIT];

  // ****************************************************************
  // Always-on power management register
  // ****************************************************************
  rec_shutdown_latch u_shutdown_latch (
    .clk_i       (clk_i),
    .rtc_por_n_i (rtc_por_n_i),
    .ce_i        (ce_i),
    .wr_i        (pm_wr),
    .wdata_i     (pm_wdata),
    .state_o     (pm_state)
  );

  assign shutdown = pm_state.bandgap_shutdown_bit || pm_state.regulator_shutdown_bit; // R1

  // ****************************************************************
  // Strap capture after reset release
  // ****************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      straps_taken_reg <= 1'b0;
      clk_sel_reg      <= 1'b0;
    end else if (ce_i && !straps_taken_reg) begin
      straps_taken_reg <= 1'b1;
      clk_sel_reg      <= clock_source_strap_i;
    end
  end

  // ****************************************************************
  // Regulator control register
  // ****************************************************************
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vsel_reg <= REC_RC_VSEL_RST;
    end else if (ce_i && rc_wr) begin
      vsel_reg <= wdata_i[REC_RC_VSEL_BIT]; // R6
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      usb_en_reg <= REC_RC_USB_EN_RST;
    end else if (ce_i) begin
      if (!straps_taken_reg) begin
        // Reset value follows the clock-source strap
        usb_en_reg <= !clock_source_strap_i; // R8 R9
      end else if (rc_wr && clk_sel_reg) begin
        usb_en_reg <= wdata_i[REC_RC_USB_EN_BIT]; // R8
      end
    end
  end

  // ****************************************************************
  // Regulator enables
  // ****************************************************************
  always_comb begin
    supply_next.analog_en  = !shutdown; // R3
    supply_next.core_en    = !shutdown && !core_regulator_strap_i; // R1 R4
    // Before the strap is captured the live clock strap decides, so the USB
    // regulator comes up in the same cycle as the analog and core regulators
    supply_next.usb_en     = !shutdown && (straps_taken_reg ? (usb_en_reg || !clk_sel_reg)
                                                            : !clock_source_strap_i); // R1 R8 R9
    supply_next.bandgap_en = !pm_state.bandgap_shutdown_bit; // R10
    supply_next.por_en     = !shutdown; // R10
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      supply_reg <= '0;
    end else if (ce_i) begin
      supply_reg <= supply_next;
    end
  end

  // ****************************************************************
  // Reset generation
  // ****************************************************************
  // With the core regulator in use, the internal POR holds the chip in
  // reset whenever the regulators are shut down
  always_comb begin
    if (!core_regulator_strap_i) begin
      chip_reset_n_next = supply_reg.por_en && supply_reg.core_en; // R5
    end else begin
      chip_reset_n_next = 1'b1; // R5
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chip_reset_n_reg <= 1'b0;
    end else if (ce_i) begin
      chip_reset_n_reg <= chip_reset_n_next;
    end
  end

  // ****************************************************************
  // Register read
  // ****************************************************************
  always_comb begin
    rdata_next = '0;
    if (pm_hit) begin
      rdata_next[REC_PM_CLKOUT_BIT]   = pm_state.clkout_en;
      rdata_next[REC_PM_REGULATOR_SHUTDOWN_BIT_BIT]   = pm_state.regulator_shutdown_bit;
      rdata_next[REC_PM_BANDGAP_SHUTDOWN_BIT_BIT]    = pm_state.bandgap_shutdown_bit;
      rdata_next[REC_PM_WAKE_DIR_BIT] = pm_state.wake_dir;
      rdata_next[REC_PM_WAKE_OUT_BIT] = pm_state.wake_out;
    end else if (rc_hit) begin
      rdata_next[REC_RC_VSEL_BIT]     = vsel_reg;
      rdata_next[REC_RC_USB_EN_BIT]   = usb_en_reg || !clk_sel_reg;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_reg <= '0;
    end else if (ce_i) begin
      if (rd_i) begin
        rdata_reg <= rdata_next;
      end else begin
        rdata_reg <= '0;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign rdata_o               = rdata_reg;
  assign analog_regulator_en_o = supply_reg.analog_en;
  assign core_regulator_out_o  = supply_reg.core_en;
  assign core_regulator_oe_o   = supply_reg.core_en; // R7
  assign core_voltage_select_o = vsel_reg; // R6
  assign usb_regulator_out_o   = supply_reg.usb_en;
  assign usb_regulator_oe_o    = supply_reg.usb_en; // R7
  assign bandgap_en_o          = supply_reg.bandgap_en;
  assign analog_por_en_o       = supply_reg.por_en;
  assign internal_por_select_o = !core_regulator_strap_i; // R5
  assign chip_reset_n_o        = chip_reset_n_reg;

endmodule

// ===== rtl/rec_pkg.sv
// Constants and types for the regulator enable control block.
// Assumes a 100 MHz system clock and a 16-bit register port with byte addresses.
package rec_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int              REC_ADDR_W       = 16;
  localparam int              REC_DATA_W       = 16;
  localparam logic [15:0]     REC_RTC_PM_OFS   = 16'h1930;
  localparam logic [15:0]     REC_REG_CTRL_OFS = 16'h7004;

  // ****************************************************************
  // Power management register fields
  // ****************************************************************
  localparam int              REC_PM_CLKOUT_BIT  = 0;
  localparam int              REC_PM_REGULATOR_SHUTDOWN_BIT_BIT  = 1;
  localparam int              REC_PM_BANDGAP_SHUTDOWN_BIT_BIT   = 2;
  localparam int              REC_PM_WAKE_DIR_BIT = 3;
  localparam int              REC_PM_WAKE_OUT_BIT = 4;
  localparam logic            REC_PM_CLKOUT_RST   = 1'h0;
  localparam logic            REC_PM_WAKE_DIR_RST = 1'h0;
  localparam logic            REC_PM_WAKE_OUT_RST = 1'h1;
  localparam logic            REC_PM_SHUTDOWN_RST = 1'h0;

  // ****************************************************************
  // Regulator control register fields
  // ****************************************************************
  localparam int              REC_RC_USB_EN_BIT = 0;
  localparam int              REC_RC_VSEL_BIT   = 1;
  localparam logic            REC_RC_VSEL_RST   = 1'h0;
  localparam logic            REC_RC_USB_EN_RST = 1'h0;

  // ****************************************************************
  // Core regulator voltage codes
  // ****************************************************************
  localparam logic            REC_VSEL_1V30     = 1'h0;
  localparam logic            REC_VSEL_1V05     = 1'h1;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic wake_out;
    logic wake_dir;
    logic bandgap_shutdown_bit;
    logic regulator_shutdown_bit;
    logic clkout_en;
  } rec_rtc_pm_t;

  typedef struct packed {
    logic analog_en;
    logic core_en;
    logic usb_en;
    logic bandgap_en;
    logic por_en;
  } rec_supply_t;

endpackage

// ===== rtl/rec_shutdown_latch.sv
// Always-on power management bits kept in the RTC core supply domain.
// Assumes rtc_por_n_i is the power-on reset of the RTC core supply, so the
// stored shutdown request survives every other reset.
`timescale 1ns/1ns
module rec_shutdown_latch
  import rec_pkg::*;
(
  // Clock and RTC supply reset
  input  wire logic        clk_i,
  input  wire logic        rtc_por_n_i,
  input  wire logic        ce_i,
  // Write port
  input  wire logic        wr_i,
  input  wire rec_rtc_pm_t wdata_i,
  // Stored state
  output rec_rtc_pm_t      state_o
);

  logic bandgap_shutdown_bit_reg;
  logic regulator_shutdown_bit_reg;
  logic clkout_reg;
  logic wake_dir_reg;
  logic wake_out_reg;

  // ****************************************************************
  // Sticky shutdown request
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rtc_por_n_i) begin
    if (!rtc_por_n_i) begin
      bandgap_shutdown_bit_reg  <= REC_PM_SHUTDOWN_RST;
      regulator_shutdown_bit_reg <= REC_PM_SHUTDOWN_RST;
    end else if (ce_i && wr_i) begin
      // Only a one is stored; a zero write never re-enables
      if (wdata_i.bandgap_shutdown_bit) begin
        bandgap_shutdown_bit_reg <= 1'b1; // R2
      end
      if (wdata_i.regulator_shutdown_bit) begin
        regulator_shutdown_bit_reg <= 1'b1; // R2
      end
    end
  end

  // ****************************************************************
  // Plain read/write bits
  // ****************************************************************
  always_ff @(posedge clk_i or negedge rtc_por_n_i) begin
    if (!rtc_por_n_i) begin
      clkout_reg   <= REC_PM_CLKOUT_RST;
      wake_dir_reg <= REC_PM_WAKE_DIR_RST;
      wake_out_reg <= REC_PM_WAKE_OUT_RST;
    end else if (ce_i && wr_i) begin
      clkout_reg   <= wdata_i.clkout_en;
      wake_dir_reg <= wdata_i.wake_dir;
      wake_out_reg <= wdata_i.wake_out;
    end
  end

  assign state_o.bandgap_shutdown_bit     = bandgap_shutdown_bit_reg;  // R11
  assign state_o.regulator_shutdown_bit    = regulator_shutdown_bit_reg; // R11
  assign state_o.clkout_en = clkout_reg;
  assign state_o.wake_dir  = wake_dir_reg;
  assign state_o.wake_out  = wake_out_reg;

endmodule

// ===== verif/rec_top_sva.sv
// Concurrent checks on the regulator enable control ports.
// Assumes straps only change while reset_n_i is low.
`timescale 1ns/1ns
module rec_top_sva
  import rec_pkg::*;
(
  // Clock, resets and register port
  input wire logic                  clk_i,
  input wire logic                  reset_n_i,
  input wire logic                  rtc_por_n_i,
  input wire logic                  ce_i,
  input wire logic [REC_ADDR_W-1:0] addr_i,
  input wire logic [REC_DATA_W-1:0] wdata_i,
  input wire logic                  wr_i,
  // Straps and regulator controls
  input wire logic                  core_regulator_strap_i,
  input wire logic                  clock_source_strap_i,
  input wire logic                  analog_regulator_en_o,
  input wire logic                  core_regulator_oe_o,
  input wire logic                  core_voltage_select_o,
  input wire logic                  usb_regulator_oe_o,
  input wire logic                  bandgap_en_o,
  input wire logic                  analog_por_en_o,
  input wire logic                  internal_por_select_o
);
  logic pm_wr;
  logic rc_wr;
  assign pm_wr = ce_i && wr_i && addr_i == REC_RTC_PM_OFS;
  assign rc_wr = ce_i && wr_i && addr_i == REC_REG_CTRL_OFS;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i || !rtc_por_n_i);

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_pd_all;
    pm_wr && (wdata_i[REC_PM_REGULATOR_SHUTDOWN_BIT_BIT] || wdata_i[REC_PM_BANDGAP_SHUTDOWN_BIT_BIT])
      |-> ##2 !analog_regulator_en_o && !core_regulator_oe_o && !usb_regulator_oe_o;
  endproperty
  a_pd_all: assert property (p_pd_all) else $error("regulator left on after shutdown");
  property p_pd_hold; $fell(analog_regulator_en_o) |=> !analog_regulator_en_o [*8]; endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("regulators came back on");
  property p_ana_on; core_regulator_oe_o || usb_regulator_oe_o |-> analog_regulator_en_o; endproperty
  a_ana_on: assert property (p_ana_on) else $error("analog regulator off alone");
  property p_core; analog_regulator_en_o |-> core_regulator_oe_o != core_regulator_strap_i; endproperty
  a_core: assert property (p_core) else $error("core regulator disagrees with strap");
  property p_por_sel; internal_por_select_o == !core_regulator_strap_i; endproperty
  a_por_sel: assert property (p_por_sel) else $error("reset source select wrong");
  property p_vsel; rc_wr |-> ##2 core_voltage_select_o == $past(wdata_i[REC_RC_VSEL_BIT], 2); endproperty
  a_vsel: assert property (p_vsel) else $error("voltage select not applied");
  property p_usb_sw;
    rc_wr && clock_source_strap_i && analog_regulator_en_o
      |-> ##2 usb_regulator_oe_o == $past(wdata_i[REC_RC_USB_EN_BIT], 2);
  endproperty
  a_usb_sw: assert property (p_usb_sw) else $error("usb enable not applied");
  property p_usb_on; !clock_source_strap_i && analog_regulator_en_o |-> usb_regulator_oe_o; endproperty
  a_usb_on: assert property (p_usb_on) else $error("usb regulator off with strap low");
  property p_bg; analog_por_en_o == analog_regulator_en_o && (bandgap_en_o || !analog_regulator_en_o); endproperty
  a_bg: assert property (p_bg) else $error("bandgap or analog reset wrong");

  c_regulator_shutdown_bit: cover property (pm_wr && wdata_i[REC_PM_REGULATOR_SHUTDOWN_BIT_BIT]);
  c_bandgap_shutdown_bit: cover property (pm_wr && wdata_i[REC_PM_BANDGAP_SHUTDOWN_BIT_BIT]);
  c_usb_sw: cover property (rc_wr && clock_source_strap_i && wdata_i[REC_RC_USB_EN_BIT]);
endmodule

bind rec_top rec_top_sva u_sva (.clk_i, .reset_n_i, .rtc_por_n_i, .ce_i, .addr_i, .wdata_i, .wr_i,
  .core_regulator_strap_i, .clock_source_strap_i, .analog_regulator_en_o, .core_regulator_oe_o,
  .core_voltage_select_o, .usb_regulator_oe_o, .bandgap_en_o, .analog_por_en_o, .internal_por_select_o);

// ===== verif/rec_board_model.sv
// Board straps and RTC core supply seen by the regulator control block.
// Assumes the bench changes strap choices only while the chip is in reset.
`timescale 1ns/1ns
module rec_board_model (
  // Bench choices
  input  wire logic core_tie_high_i,
  input  wire logic clk_tie_high_i,
  input  wire logic rtc_cycle_i,
  // Board levels
  output logic      core_regulator_strap_o,
  output logic      clock_source_strap_o,
  output logic      rtc_por_n_o
);
  // Straps are hard-wired levels, never left floating
  assign core_regulator_strap_o = core_tie_high_i;
  assign clock_source_strap_o   = clk_tie_high_i;
  // Supply-good reset is low for the whole RTC supply cycle
  assign rtc_por_n_o            = !rtc_cycle_i;
endmodule

// ===== verif/regulator_enable_control_tb_top.sv
// Self-checking bench for the regulator enable control block.
// Assumes the board model supplies straps and the RTC supply reset.
`timescale 1ns/1ns
module regulator_enable_control_tb_top
  import rec_pkg::*;
;
  logic        clk_i, reset_n_i, wr_i, rd_i, ce, core_hi, clk_hi, rtc_cycle, rtc_por_n, core_strap, clk_strap;
  logic        core_out, usb_out, ana, core_oe, usb_oe, vsel, bg, por, por_sel, chip_rst_n;
  logic [15:0] addr_i, wdata_i, rdata_o;
  logic [9:0]  pins;
  int          num_errors, n_compared, cycles;
  assign pins = {core_out, usb_out, ana, core_oe, usb_oe, vsel, bg, por, por_sel, chip_rst_n};

  rec_board_model u_board (.core_tie_high_i(core_hi), .clk_tie_high_i(clk_hi), .rtc_cycle_i(rtc_cycle),
    .core_regulator_strap_o(core_strap), .clock_source_strap_o(clk_strap), .rtc_por_n_o(rtc_por_n));
  rec_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .rtc_por_n_i(rtc_por_n), .ce_i(ce),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .core_regulator_strap_i(core_strap), .clock_source_strap_i(clk_strap), .analog_regulator_en_o(ana),
    .core_regulator_out_o(core_out), .core_regulator_oe_o(core_oe), .core_voltage_select_o(vsel),
    .usb_regulator_out_o(usb_out), .usb_regulator_oe_o(usb_oe), .bandgap_en_o(bg), .analog_por_en_o(por),
    .internal_por_select_o(por_sel), .chip_reset_n_o(chip_rst_n));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic test_done();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Pin vector: core out, usb out, analog, core oe, usb oe, vsel, bandgap, por, por select, chip reset
  task automatic cmp_pins(input logic [9:0] exp);
    repeat (3) @(posedge clk_i);
    #1;
    cmp_reg({6'h00, pins}, {6'h00, exp});
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    wr_i <= 1'h1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    @(posedge clk_i);
    rd_i <= 1'h1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'h0;
    #1;
    cmp_reg(rdata_o, exp);
    // Read data stands for one cycle only
    @(posedge clk_i);
    #1;
    cmp_reg(rdata_o, 16'h0000);
  endtask
  task automatic rst(input logic core, input logic clk, input logic cyc);
    @(posedge clk_i);
    reset_n_i <= 1'h0;
    rtc_cycle <= cyc;
    core_hi <= core;
    clk_hi <= clk;
    repeat (3) @(posedge clk_i);
    reset_n_i <= 1'h1;
    rtc_cycle <= 1'h0;
  endtask

  // ****************************************************************
  // Clock, timeout and sequence
  // ****************************************************************
  initial begin
    clk_i = 1'h0;
    forever #5 clk_i = !clk_i;
  end
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      test_done();
    end
  end
  initial begin
    {reset_n_i, wr_i, rd_i, core_hi, clk_hi} = 5'h00;
    ce = 1'h1;
    rtc_cycle = 1'h1;
    addr_i = 16'h0000;
    wdata_i = 16'h0000;
    rst(1'h0, 1'h1, 1'h1);
    cmp_pins(10'h2CF);
    rd(REC_REG_CTRL_OFS, 16'h0000);
    rd(REC_RTC_PM_OFS, 16'h0010);
    wr(REC_REG_CTRL_OFS, 16'h0003);
    cmp_pins(10'h3FF);
    rd(REC_REG_CTRL_OFS, 16'h0003);
    wr(REC_REG_CTRL_OFS, 16'h0000);
    cmp_pins(10'h2CF);
    // Clock enable low: a write must leave every state untouched
    @(posedge clk_i);
    ce <= 1'h0;
    wr(REC_REG_CTRL_OFS, 16'h0003);
    cmp_pins(10'h2CF);
    @(posedge clk_i);
    ce <= 1'h1;
    rd(REC_REG_CTRL_OFS, 16'h0000);
    wr(16'h0100, 16'hFFFF);
    rd(16'h0100, 16'h0000);
    cmp_pins(10'h2CF);
    wr(REC_RTC_PM_OFS, 16'h0002);
    cmp_pins(10'h00A);
    wr(REC_RTC_PM_OFS, 16'h0000);
    wr(REC_REG_CTRL_OFS, 16'h0001);
    cmp_pins(10'h00A);
    rd(REC_RTC_PM_OFS, 16'h0002);
    rst(1'h0, 1'h1, 1'h0);
    cmp_pins(10'h00A);
    rst(1'h0, 1'h1, 1'h1);
    wr(REC_RTC_PM_OFS, 16'h0004);
    cmp_pins(10'h002);
    rd(REC_RTC_PM_OFS, 16'h0004);
    rst(1'h1, 1'h0, 1'h1);
    cmp_pins(10'h1AD);
    wr(REC_REG_CTRL_OFS, 16'h0000);
    cmp_pins(10'h1AD);
    rd(REC_REG_CTRL_OFS, 16'h0001);
    wr(REC_RTC_PM_OFS, 16'h0002);
    cmp_pins(10'h009);
    test_done();
  end
endmodule
